/* hw/amp_cfg.svh */
`ifndef AMP_CFG_SVH
`define AMP_CFG_SVH

// register offsets, book 0 page 0
`define OFS_RAMP 8'h08
`define OFS_EDGE 8'h09
`define OFS_SYN_IN 8'h0f
`define OFS_SYN_INT 8'h10
`define OFS_SYN_FRAC 8'h11

// reset values
`define RST_RAMP 8'h01
`define RST_EDGE 8'h83
`define RST_SYN_IN 8'h41
`define RST_SYN_INT 8'h04
`define RST_SYN_FRAC 8'h00

// bank size and slot order
`define NREGS 5
`define IDX_RAMP 0
`define IDX_EDGE 1
`define IDX_SYN_IN 2
`define IDX_SYN_INT 3
`define IDX_SYN_FRAC 4

// field positions
`define F_RAMP_SRC 7:6
`define F_RAMP_RATE 5:4
`define F_RAMP_DEPTH 1:0
`define F_EDGE 7:5
`define F_ISNS 4:3
`define F_BOOST 1:0
`define F_SYN_SRC 7:6
`define F_PRE_DIV 5:0
`define B_SLOW 7
`define F_MULT_J 6:0
`define F_FRAC_HI 5:0

// field codes with a meaning
`define RAMP_RATE_48K 2'h0
`define RAMP_RATE_44K 2'h1
`define DEPTH_LO 2'h1
`define DEPTH_HI 2'h2
`define ISNS_RSVD 2'h3
`define PRE_DIV_ZERO 6'h00
`define MULT_J_ZERO 7'h00
`define MULT_J_MAX 7'h3f

// physical values of the codes
`define RAMP_HZ_48K 19'h54f60
`define RAMP_HZ_44K 19'h56220
`define DEPTH_PCT_LO 4'h5
`define DEPTH_PCT_HI 4'ha
`define PRE_DIV_MAX 7'h40
`define EDGE_NS_2 5'h1d
`define EDGE_NS_3 5'h19
`define EDGE_NS_4 5'h0e
`define EDGE_NS_5 5'h0d
`define EDGE_NS_6 5'h0c
`define EDGE_NS_7 5'h0b
`define ISNS_MA_0 11'h4e2
`define ISNS_MA_1 11'h5dc
`define ISNS_MA_2 11'h6d6
`define BOOST_MA_0 12'h5dc
`define BOOST_MA_1 12'h7d0
`define BOOST_MA_2 12'h9c4
`define BOOST_MA_3 12'hbb8

`endif

/* hw/amp_cfg_pkg.sv */
package amp_cfg_pkg;

  // ramp clock origin, in field code order
  typedef enum logic [1:0] {
    ramp_src_audio_sync,
    ramp_src_fixed_osc,
    ramp_src_spread_osc,
    ramp_src_reserved
  } ramp_source_t;

  // synthesiser input origin, in field code order
  typedef enum logic [1:0] {
    syn_src_bit_clock,
    syn_src_master_clock,
    syn_src_density_modulation_clock,
    syn_src_reserved
  } synth_source_t;

  // one access from the host control port
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    ramp_source_t source;
    logic fixed_oscillator_ramp;
    logic spread_spectrum_ramp;
    logic [18:0] ramp_nominal_frequency_hz;
    logic [3:0] spread_depth_pct;
    logic reserved_code;
  } ramp_cfg_t;

  typedef struct packed {
    logic [4:0] edge_ns;
    logic [10:0] current_sense_full_scale_ma;
    logic [11:0] boost_current_limit_ma;
    logic reserved_code;
  } drive_cfg_t;

  typedef struct packed {
    synth_source_t synth_input_source;
    logic [6:0] pre_divide;
    logic synth_slow_input_flag;
    logic [6:0] synth_integer_multiplier;
    logic [5:0] synth_fraction_multiplier_high;
    logic reserved_code;
  } synth_cfg_t;

endpackage : amp_cfg_pkg

/* hw/amp_ramp_edge_pll_config.sv */
`timescale 1ns/1ps
`default_nettype none
`include "amp_cfg.svh"

module amp_ramp_edge_pll_config
  import amp_cfg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire reg_req_t host_req,
  output logic host_hit,
  output logic [7:0] host_rdata,
  output logic host_rvalid,
  output ramp_cfg_t ramp_cfg,
  output drive_cfg_t drive_cfg,
  output synth_cfg_t synth_cfg
);

  ////////////////////////////////////////////////////////////////////////////
  // register bank

  // slot count is fixed by the register map
  localparam int NREGS = `NREGS;

  // offsets and reset values packed by slot, slot 0 in the low byte
  localparam logic [8*NREGS-1:0] OFS_PACK = {
    `OFS_SYN_FRAC,
    `OFS_SYN_INT,
    `OFS_SYN_IN,
    `OFS_EDGE,
    `OFS_RAMP
  };
  // reset values in the same slot order
  localparam logic [8*NREGS-1:0] RST_PACK = {
    `RST_SYN_FRAC,
    `RST_SYN_INT,
    `RST_SYN_IN,
    `RST_EDGE,
    `RST_RAMP
  };

  // bank storage, its next values and the read or-chain
  logic [7:0] bank_reg [NREGS];
  logic [7:0] bank_next [NREGS];
  logic [NREGS-1:0] slot_sel;
  logic [7:0] rd_or [NREGS+1];

  // chain seed; each slot or-s in its byte only when addressed
  assign rd_or[0] = 8'h00;

  // one slot per register: decode, write, reset, read term;
  // a new register costs one offset, one reset value and one slot index
  genvar gi;
  generate
    for (gi = 0; gi < NREGS; gi++)
    begin : g_slot
      wire [7:0] slot_ofs = OFS_PACK[8*gi +: 8];
      wire [7:0] slot_rst = RST_PACK[8*gi +: 8];
      wire slot_wr;

      // full eight-bit match, so the neighbour at 0x12 never aliases
      assign slot_sel[gi] = (host_req.addr == slot_ofs);
      assign slot_wr = host_req.wr & slot_sel[gi];
      // every bit is stored as written, reserved codes too
      assign bank_next[gi] = slot_wr ? host_req.wdata : bank_reg[gi];
      // this slot's read term
      assign rd_or[gi+1] = rd_or[gi] | (slot_sel[gi] ? bank_reg[gi] : 8'h00);

      // defaults come back on reset
      always_ff @(posedge clk_sys)
      begin
        if (rst)
          bank_reg[gi] <= slot_rst;
        else
          bank_reg[gi] <= bank_next[gi];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // host readback

  // unmapped offsets answer zero so a neighbouring bank can be or-ed in
  wire any_hit = |slot_sel;
  wire [7:0] rdata_next = host_req.rd ? rd_or[NREGS] : 8'h00;
  logic [7:0] rdata_reg;
  logic rvalid_reg;

  // hit stays combinational so a neighbouring bank can steer its answer
  assign host_hit = any_hit;

  // read data is the bank before a same-cycle write lands
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= rdata_next;
  end

  // one pulse per read strobe, mapped or not,
  // so the host never waits on a hole in the map
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      rvalid_reg <= 1'b0;
    else
      rvalid_reg <= host_req.rd;
  end

  // answers go straight from the flops to the port
  assign host_rdata = rdata_reg;
  assign host_rvalid = rvalid_reg;

  ////////////////////////////////////////////////////////////////////////////
  // field extraction

  // raw register bytes, one name per slot
  wire [7:0] r_ramp = bank_reg[`IDX_RAMP];
  wire [7:0] r_edge = bank_reg[`IDX_EDGE];
  wire [7:0] r_in = bank_reg[`IDX_SYN_IN];
  wire [7:0] r_int = bank_reg[`IDX_SYN_INT];
  wire [7:0] r_frac = bank_reg[`IDX_SYN_FRAC];

  // ramp register fields
  wire [1:0] ramp_src_code = r_ramp[`F_RAMP_SRC];
  wire [1:0] ramp_rate_code = r_ramp[`F_RAMP_RATE];
  wire [1:0] depth_code = r_ramp[`F_RAMP_DEPTH];

  // output stage register fields
  wire [2:0] edge_code = r_edge[`F_EDGE];
  wire [1:0] isns_code = r_edge[`F_ISNS];
  wire [1:0] boost_code = r_edge[`F_BOOST];

  // synthesiser register fields
  wire [1:0] syn_src_code = r_in[`F_SYN_SRC];
  wire [5:0] pre_div_code = r_in[`F_PRE_DIV];
  wire slow_flag = r_int[`B_SLOW];
  wire [6:0] mult_j_code = r_int[`F_MULT_J];
  wire [5:0] frac_hi = r_frac[`F_FRAC_HI];

  ////////////////////////////////////////////////////////////////////////////
  // ramp clock decode

  // source decode; the two oscillator flags feed the ramp generator
  wire ramp_src_rsvd = (ramp_src_code == 2'(ramp_src_reserved));
  wire use_fixed = (ramp_src_code == 2'(ramp_src_fixed_osc));
  wire use_spread = (ramp_src_code == 2'(ramp_src_spread_osc));

  // nominal frequency; reserved codes give zero
  wire freq_48k = (ramp_rate_code == `RAMP_RATE_48K);
  wire freq_44k = (ramp_rate_code == `RAMP_RATE_44K);
  wire [18:0] ramp_hz =
    freq_48k ? `RAMP_HZ_48K :
    freq_44k ? `RAMP_HZ_44K : 19'h00000;

  // depth only matters while spreading; zero otherwise,
  // so a stale code under a fixed ramp cannot leak a depth
  wire depth_lo = (depth_code == `DEPTH_LO);
  wire depth_hi = (depth_code == `DEPTH_HI);
  wire [3:0] depth_pct =
    !use_spread ? 4'h0 :
    depth_lo ? `DEPTH_PCT_LO :
    depth_hi ? `DEPTH_PCT_HI : 4'h0;

  // depth code is checked only where it is used
  wire freq_rsvd = !(freq_48k | freq_44k);
  wire depth_rsvd = use_spread & !(depth_lo | depth_hi);
  wire ramp_rsvd = ramp_src_rsvd | freq_rsvd | depth_rsvd;
  // one flag for the whole ramp group keeps the output narrow

  ////////////////////////////////////////////////////////////////////////////
  // output stage decode

  // transition time, one match per defined code; codes 0 and 1 give zero
  wire edge_c2 = (edge_code == 3'h2);
  wire edge_c3 = (edge_code == 3'h3);
  wire edge_c4 = (edge_code == 3'h4);
  wire edge_c5 = (edge_code == 3'h5);
  wire edge_c6 = (edge_code == 3'h6);
  wire edge_c7 = (edge_code == 3'h7);
  wire [4:0] edge_ns =
    edge_c2 ? `EDGE_NS_2 :
    edge_c3 ? `EDGE_NS_3 :
    edge_c4 ? `EDGE_NS_4 :
    edge_c5 ? `EDGE_NS_5 :
    edge_c6 ? `EDGE_NS_6 :
    edge_c7 ? `EDGE_NS_7 : 5'h00;
  // flagged from the code, not the time, so a zero table entry cannot hide
  wire edge_rsvd = !(edge_c2 | edge_c3 | edge_c4 | edge_c5 | edge_c6 | edge_c7);

  // sense full scale; host picks code from speaker resistance
  wire isns_c0 = (isns_code == 2'h0);
  wire isns_c1 = (isns_code == 2'h1);
  wire isns_c2 = (isns_code == 2'h2);
  wire [10:0] isns_ma =
    isns_c0 ? `ISNS_MA_0 :
    isns_c1 ? `ISNS_MA_1 :
    isns_c2 ? `ISNS_MA_2 : 11'h000;
  wire isns_rsvd = (isns_code == `ISNS_RSVD);

  // all four limit codes are legal, so no reserved flag here
  wire boost_c0 = (boost_code == 2'h0);
  wire boost_c1 = (boost_code == 2'h1);
  wire boost_c2 = (boost_code == 2'h2);
  wire [11:0] boost_ma =
    boost_c0 ? `BOOST_MA_0 :
    boost_c1 ? `BOOST_MA_1 :
    boost_c2 ? `BOOST_MA_2 : `BOOST_MA_3;

  ////////////////////////////////////////////////////////////////////////////
  // synthesiser decode

  // code 3 of the input source has no clock behind it
  wire syn_src_rsvd = (syn_src_code == 2'(syn_src_reserved));

  // zero stands for the largest ratio, so widen by one bit;
  // the divider downstream sees a divide by zero only in reset and the one cycle after it, until synth_cfg loads
  wire [6:0] pre_div =
    (pre_div_code == `PRE_DIV_ZERO) ? `PRE_DIV_MAX
                                    : {1'b0, pre_div_code};

  // only 1..63 are defined ratios; the field is seven bits wide,
  // so the codes above 63 are flagged as well
  wire mult_j_zero = (mult_j_code == `MULT_J_ZERO);
  wire mult_j_high = (mult_j_code > `MULT_J_MAX);
  wire mult_j_rsvd = mult_j_zero | mult_j_high;

  // source and multiplier are the only synth fields with holes;
  // the slow-input flag is not judged, the host owns it
  wire syn_rsvd = syn_src_rsvd | mult_j_rsvd;

  ////////////////////////////////////////////////////////////////////////////
  // registered configuration outputs

  // next values of the three output groups
  ramp_cfg_t ramp_next;
  drive_cfg_t drive_next;
  synth_cfg_t synth_next;

  // ramp group: code, decoded flags, physical values
  assign ramp_next.source = ramp_source_t'(ramp_src_code);
  assign ramp_next.fixed_oscillator_ramp = use_fixed;
  assign ramp_next.spread_spectrum_ramp = use_spread;
  assign ramp_next.ramp_nominal_frequency_hz = ramp_hz;
  assign ramp_next.spread_depth_pct = depth_pct;
  assign ramp_next.reserved_code = ramp_rsvd;

  // output stage group
  assign drive_next.edge_ns = edge_ns;
  assign drive_next.current_sense_full_scale_ma = isns_ma;
  assign drive_next.boost_current_limit_ma = boost_ma;
  assign drive_next.reserved_code = edge_rsvd | isns_rsvd;

  // synthesiser group
  assign synth_next.synth_input_source = synth_source_t'(syn_src_code);
  assign synth_next.pre_divide = pre_div;
  // the device only carries the flag; choosing it is the host's job
  assign synth_next.synth_slow_input_flag = slow_flag;
  assign synth_next.synth_integer_multiplier = mult_j_code;
  assign synth_next.synth_fraction_multiplier_high = frac_hi;
  assign synth_next.reserved_code = syn_rsvd;

  // settings leave through flops, one cycle after the bank changes;
  // zero in reset so nothing downstream acts on a half-built setting
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      ramp_cfg <= '0;
    else
      ramp_cfg <= ramp_next;
  end

  // output stage settings, same one-cycle lag
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      drive_cfg <= '0;
    else
      drive_cfg <= drive_next;
  end

  // synthesiser settings, same one-cycle lag
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      synth_cfg <= '0;
    else
      synth_cfg <= synth_next;
  end

endmodule : amp_ramp_edge_pll_config
`default_nettype wire

/* sim/amp_cfg_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module amp_cfg_checker
  import amp_cfg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire reg_req_t host_req,
  input wire logic host_hit,
  input wire logic [7:0] host_rdata,
  input wire logic host_rvalid,
  input wire ramp_cfg_t ramp_cfg,
  input wire drive_cfg_t drive_cfg,
  input wire synth_cfg_t synth_cfg
);
  // single clock domain, reset masks everything
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire wr9 = host_req.wr && host_req.addr == 8'h09;
  wire wr11 = host_req.wr && host_req.addr == 8'h11;
  //////////////////////////////////////////////////
  // port answers
  a_read_answers: assert property (host_req.rd |=> host_rvalid)
    else $error("read not answered");
  a_idle_quiet: assert property (!host_req.rd |=> !host_rvalid && host_rdata == 8'h00)
    else $error("stray read data");
  a_hole_zero: assert property (host_req.rd && !host_hit |=> host_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_hit_decode: assert property (host_hit == (host_req.addr inside {8'h08, 8'h09,
    8'h0f, 8'h10, 8'h11}))
    else $error("address decode wrong");
  a_write_reads_back: assert property (host_req.rd && !host_req.wr && !$past(rst)
    && $past(host_req.wr) && $past(host_hit) && host_req.addr == $past(host_req.addr)
    |=> host_rdata == $past(host_req.wdata, 2))
    else $error("readback differs from write");
  // decoded outputs, one edge behind the bank
  a_edge_code_five: assert property (wr9 && host_req.wdata[7:5] == 3'h5 ##1 !wr9
    |=> drive_cfg.edge_ns == 5'h0d)
    else $error("edge rate decode wrong");
  a_frac_follows: assert property (wr11 ##1 !wr11
    |=> synth_cfg.synth_fraction_multiplier_high == $past(host_req.wdata[5:0], 2))
    else $error("fraction high wrong");
  // pre-divide must stay within 1..64 once out of reset, never read as 0
  a_prediv_range: assert property (!$past(rst) && !$past(rst, 2)
    |-> synth_cfg.pre_divide inside {[7'h01:7'h40]})
    else $error("pre-divide out of range");
  cover property (wr9 ##1 !wr9);
  cover property (host_req.rd && !host_hit);
  cover property (host_req.wr ##1 host_req.rd);
endmodule : amp_cfg_checker
bind amp_ramp_edge_pll_config amp_cfg_checker amp_cfg_checker_i (.clk_sys(clk_sys),
  .rst(rst), .host_req(host_req), .host_hit(host_hit), .host_rdata(host_rdata),
  .host_rvalid(host_rvalid), .ramp_cfg(ramp_cfg), .drive_cfg(drive_cfg),
  .synth_cfg(synth_cfg));
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import amp_cfg_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  reg_req_t host_req = '0;
  logic host_hit;
  logic [7:0] host_rdata;
  logic host_rvalid;
  ramp_cfg_t ramp_cfg;
  drive_cfg_t drive_cfg;
  synth_cfg_t synth_cfg;
  int fail_count = 0;
  int checked = 0;
  // expected decodes, indexed by field code
  logic [4:0] ns_tab [8] = '{5'h00, 5'h00, 5'h1d, 5'h19, 5'h0e, 5'h0d, 5'h0c, 5'h0b};
  logic [10:0] isns_tab [4] = '{11'h4e2, 11'h5dc, 11'h6d6, 11'h000};
  logic [11:0] boost_tab [4] = '{12'h5dc, 12'h7d0, 12'h9c4, 12'hbb8};
  logic [18:0] hz_tab [4] = '{19'h54f60, 19'h56220, 19'h00000, 19'h00000};
  logic [7:0] ofs [5] = '{8'h08, 8'h09, 8'h0f, 8'h10, 8'h11};
  logic [7:0] dflt [5] = '{8'h01, 8'h83, 8'h41, 8'h04, 8'h00};

  always #2 clk_sys = ~clk_sys;

  amp_ramp_edge_pll_config amp_ramp_edge_pll_config_i (.clk_sys(clk_sys), .rst(rst),
    .host_req(host_req), .host_hit(host_hit), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid), .ramp_cfg(ramp_cfg), .drive_cfg(drive_cfg),
    .synth_cfg(synth_cfg));
  //////////////////////////////////////////////////
  task automatic chk(input logic [18:0] got, input logic [18:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // read answer is fixed at one cycle, so no open wait
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    host_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk_sys);
    host_req.rd <= 1'b0;
    #1;
    chk(host_rvalid, 1'b1);
    chk(host_rdata, exp);
  endtask : rd_reg

  // write then read straight after, to catch a stale bank
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
    @(posedge clk_sys);
    host_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk_sys);
    host_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk_sys);
    host_req.rd <= 1'b0;
    #1;
    chk(host_rdata, exp);
  endtask : wr_reg

  task automatic complete_run;
    $display("checks %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  //////////////////////////////////////////////////
  initial
  begin
    logic [7:0] d;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++)
      rd_reg(ofs[i], dflt[i]);
    chk(drive_cfg.edge_ns, 5'h0e);
    chk(synth_cfg.synth_input_source, syn_src_master_clock);
    chk(synth_cfg.synth_integer_multiplier, 7'h04);
    chk(drive_cfg.boost_current_limit_ma, 12'hbb8);
    chk(synth_cfg.pre_divide, 7'h01);
    $display("test defaults done");
    // every edge, sense and boost code
    for (int c = 0; c < 8; c++)
    begin
      d = {c[2:0], c[1:0], 1'b0, c[1:0]};
      wr_reg(8'h09, d, d);
      chk(drive_cfg.edge_ns, ns_tab[c]);
      chk(drive_cfg.current_sense_full_scale_ma, isns_tab[c[1:0]]);
      chk(drive_cfg.boost_current_limit_ma, boost_tab[c[1:0]]);
      chk(drive_cfg.reserved_code, c < 2 || c[1:0] == 2'h3);
    end
    // every ramp source and frequency code
    for (int c = 0; c < 4; c++)
    begin
      d = {c[1:0], c[1:0], 2'h0, c[1:0]};
      wr_reg(8'h08, d, d);
      chk(ramp_cfg.source, c[1:0]);
      chk(ramp_cfg.fixed_oscillator_ramp, c == 1);
      chk(ramp_cfg.spread_spectrum_ramp, c == 2);
      chk(ramp_cfg.ramp_nominal_frequency_hz, hz_tab[c[1:0]]);
      chk(ramp_cfg.spread_depth_pct, (c == 2) ? 4'ha : 4'h0);
      chk(ramp_cfg.reserved_code, c > 1);
    end
    wr_reg(8'h08, 8'h80, 8'h80);
    chk(ramp_cfg.spread_depth_pct, 4'h0);
    chk(ramp_cfg.reserved_code, 1'b1);
    wr_reg(8'h08, 8'h81, 8'h81);
    chk(ramp_cfg.spread_depth_pct, 4'h5);
    chk(ramp_cfg.reserved_code, 1'b0);
    $display("test ramp and drive done");
    wr_reg(8'h0f, 8'h80, 8'h80);
    chk(synth_cfg.pre_divide, 7'h40);
    chk(synth_cfg.synth_input_source, syn_src_density_modulation_clock);
    wr_reg(8'h0f, 8'h3f, 8'h3f);
    chk(synth_cfg.pre_divide, 7'h3f);
    chk(synth_cfg.synth_input_source, syn_src_bit_clock);
    wr_reg(8'h10, 8'h80, 8'h80);
    chk(synth_cfg.synth_slow_input_flag, 1'b1);
    chk(synth_cfg.reserved_code, 1'b1);
    wr_reg(8'h10, 8'h3f, 8'h3f);
    chk(synth_cfg.synth_integer_multiplier, 7'h3f);
    chk(synth_cfg.reserved_code, 1'b0);
    chk(synth_cfg.synth_slow_input_flag, 1'b0);
    wr_reg(8'h10, 8'h40, 8'h40);
    chk(synth_cfg.synth_integer_multiplier, 7'h40);
    chk(synth_cfg.reserved_code, 1'b1);
    wr_reg(8'h10, 8'h01, 8'h01);
    chk(synth_cfg.synth_integer_multiplier, 7'h01);
    chk(synth_cfg.reserved_code, 1'b0);
    wr_reg(8'h0f, 8'hc5, 8'hc5);
    chk(synth_cfg.synth_input_source, syn_src_reserved);
    chk(synth_cfg.pre_divide, 7'h05);
    chk(synth_cfg.reserved_code, 1'b1);
    wr_reg(8'h11, 8'hff, 8'hff);
    chk(synth_cfg.synth_fraction_multiplier_high, 6'h3f);
    wr_reg(8'h12, 8'h55, 8'h00);
    rd_reg(8'h11, 8'hff);
    $display("test synth and hole done");
    // reset again mid-run, bank must fall back
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd_reg(8'h11, 8'h00);
    rd_reg(8'h09, 8'h83);
    chk(drive_cfg.edge_ns, 5'h0e);
    chk(drive_cfg.boost_current_limit_ma, 12'hbb8);
    chk(synth_cfg.synth_fraction_multiplier_high, 6'h00);
    $display("test second reset done");
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
